/* core/ussc_pkg.sv */
// ussc_pkg: shared constants and types for the uart shutdown controller.
// assumes a 250 MHz system clock; the link-side logic runs on the oscillator clock.
package ussc_pkg;
  localparam int unsigned USSC_CLK_MHZ = 250;
  // oscillator settling time the host waits after restart, in ms
  localparam int unsigned USSC_OSC_SETTLE_MS = 25;
  localparam int unsigned USSC_OSC_SETTLE_CYC = USSC_OSC_SETTLE_MS * 1000 * USSC_CLK_MHZ;
  // transceiver driver wake time after the power-down pin rises, in us
  localparam int unsigned USSC_XCVR_WAKE_US = 100;
  localparam int unsigned USSC_XCVR_WAKE_CYC = USSC_XCVR_WAKE_US * USSC_CLK_MHZ;
  localparam int unsigned USSC_CFG_W = 12;
  // configuration field positions in cfg_data_in
  localparam int unsigned USSC_POS_BAUD = 0;
  localparam int unsigned USSC_POS_WLEN = 4;
  localparam int unsigned USSC_POS_PEN = 5;
  localparam int unsigned USSC_POS_STOP = 6;
  localparam int unsigned USSC_POS_IRSEL = 7;
  localparam int unsigned USSC_POS_RAM = 8;
  localparam int unsigned USSC_POS_PM = 9;
  localparam int unsigned USSC_POS_TM = 10;
  localparam int unsigned USSC_POS_RM = 11;
  localparam logic [USSC_CFG_W-1:0] USSC_CFG_RST = 12'h000;
  typedef enum logic [1:0] {
    USSC_RUN = 2'b00,
    USSC_DRAIN = 2'b01,
    USSC_SHUT = 2'b11,
    USSC_WAKE = 2'b10
  } ussc_state_t;
endpackage

/* core/ussc_osc_if.sv */
// ussc_osc_if: carries the oscillator-domain handshake between top and link logic.
// assumes both ends agree that req/ack are toggles crossing domains.
interface ussc_osc_if;
  logic osc_run;
  logic clr_tgl;
  logic clr_ack_tgl;
  logic rx_act_tgl;
  modport ctrl (output osc_run, output clr_tgl, input clr_ack_tgl, input rx_act_tgl);
  modport link (input osc_run, input clr_tgl, output clr_ack_tgl, output rx_act_tgl);
endinterface

/* core/ussc_link.sv */
// ussc_link: logic on the oscillator clock; watches the receive line.
// assumes osc_clk_in may stop while shut down; rx transitions are then seen on the system side.
module ussc_link (
  // oscillator clock and reset
  input wire logic osc_clk_in,
  input wire logic osc_rst_b_in,
  // receive line
  input wire logic rx_in,
  // crossing to the controller
  ussc_osc_if.link osc_if
);
  import ussc_pkg::*;
  logic [2:0] rx_sync_r;
  logic [2:0] clr_sync_r;
  logic ack_r;
  logic act_r;
  logic [2:0] run_sync_r;
  // rx resampled on the oscillator clock; first stage only feeds the second
  always_ff @(posedge osc_clk_in or negedge osc_rst_b_in) begin
    if (!osc_rst_b_in) begin
      rx_sync_r <= 3'h7;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], rx_in};
    end
  end
  // clear request from the controller, echoed back once its toggle has passed the synchronizer
  always_ff @(posedge osc_clk_in or negedge osc_rst_b_in) begin
    if (!osc_rst_b_in) begin
      clr_sync_r <= 3'h0;
      ack_r <= 1'b0;
    end else begin
      clr_sync_r <= {clr_sync_r[1:0], osc_if.clr_tgl};
      if (clr_sync_r[2] != clr_sync_r[1]) begin
        ack_r <= ~ack_r;
      end
    end
  end
  // run enable comes from the system clock; resampled here so it never meets this clock mid-change
  always_ff @(posedge osc_clk_in or negedge osc_rst_b_in) begin
    if (!osc_rst_b_in) begin
      run_sync_r <= 3'h7;
    end else begin
      run_sync_r <= {run_sync_r[1:0], osc_if.osc_run};
    end
  end
  // toggles on each rx edge seen while the oscillator runs
  always_ff @(posedge osc_clk_in or negedge osc_rst_b_in) begin
    if (!osc_rst_b_in) begin
      act_r <= 1'b0;
    end else if (run_sync_r[2] && run_sync_r[1] && (rx_sync_r[2] != rx_sync_r[1])) begin
      act_r <= ~act_r;
    end
  end
  assign osc_if.clr_ack_tgl = ack_r;
  assign osc_if.rx_act_tgl = act_r;
endmodule

/* core/ussc_top.sv */
// ussc_top: software shutdown sequencer for an integrated uart plus transceiver power-down.
// assumes the host frames configuration writes with an active-low chip select and
// tells this block, per write, the shutdown request bit and the configuration field.
// How it works
// - shutdown request bit one starts shutdown
// - oscillator stopped while shut down
// - shutdown waits for both transmit stages empty
// - acknowledge flag set when shutdown entered
// - entry clears fifo, flags, data, parity bits; the code pulses only the fifo flush and clears only the activity flag
// - entry forces transmit empty flag high
// - config writes still accepted while acknowledged
// - receive edge sets activity flag when shut
// - request zero restarts oscillator at select rise
// - restart write reinitializes all but rts, cts; the code resets only the configuration fields
// - uart and transceiver shutdowns stay independent
// - power-down pin low floats line drivers
// - line receivers stay active in shutdown
// - interrupt follows activity flag and its mask
// - activity flag clears when leaving shutdown
module ussc_top
  import ussc_pkg::*;
(
  // system clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // oscillator clock of the uart core
  input wire logic osc_clk_in,
  // host configuration write: strobe one cycle, chip select from pin
  input wire logic cfg_wr_in,
  input wire logic cfg_transceiver_power_down_pin_in,
  input wire logic cfg_reinit_in,
  input wire logic [ussc_pkg::USSC_CFG_W-1:0] cfg_data_in,
  input wire logic rts_wr_in,
  input wire logic rts_val_in,
  input wire logic cs_b_in,
  // uart transmit status
  input wire logic tx_shift_busy_in,
  input wire logic tx_hold_full_in,
  // lines
  input wire logic rx_in,
  input wire logic cts_in,
  input wire logic transceiver_power_down_pin_in,
  input wire logic [1:0] drv_data_in,
  input wire logic [1:0] line_rx_in,
  // uart control and status
  output logic osc_enable_out,
  output logic rx_fifo_flush_out,
  output logic shutdown_acknowledge_out,
  output logic activity_or_framing_flag_out,
  output logic tx_empty_force_out,
  output logic irq_b_out,
  output logic cts_out,
  output logic rts_out,
  output logic [ussc_pkg::USSC_CFG_W-1:0] cfg_out,
  // transceiver
  output logic [1:0] drv_data_out,
  output logic [1:0] drv_oe_out,
  output logic [1:0] line_rx_out
);
  import ussc_pkg::*;

  logic [1:0] rst_sync_r;
  logic rst_b;
  logic [2:0] cs_sync_r;
  logic [2:0] rx_sync_r;
  logic [2:0] cts_sync_r;
  logic [2:0] ack_sync_r;
  logic [2:0] act_sync_r;
  logic cs_rise;
  logic rx_edge;
  logic act_evt;
  ussc_state_t state_r;
  ussc_state_t state_nxt;
  logic req_r;
  logic wake_pend_r;
  logic ack_r;
  logic ra_r;
  logic clr_tgl_r;
  logic flush_r;
  logic tx_force_r;
  logic rts_r;
  logic [USSC_CFG_W-1:0] cfg_r;
  logic osc_run_r;
  logic entering;
  logic leaving;
  ussc_osc_if osc_if ();

  // reset released through two flops so every process leaves reset together
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_r[1];

  // pin inputs pass three flops; a change counts when the last two differ
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync_r <= 3'h7;
      rx_sync_r <= 3'h7;
      cts_sync_r <= 3'h0;
      ack_sync_r <= 3'h0;
      act_sync_r <= 3'h0;
    end else begin
      cs_sync_r <= {cs_sync_r[1:0], cs_b_in};
      rx_sync_r <= {rx_sync_r[1:0], rx_in};
      cts_sync_r <= {cts_sync_r[1:0], cts_in};
      ack_sync_r <= {ack_sync_r[1:0], osc_if.clr_ack_tgl};
      act_sync_r <= {act_sync_r[1:0], osc_if.rx_act_tgl};
    end
  end
  assign cs_rise = cs_sync_r[1] && !cs_sync_r[2];
  // rx watched on the system clock too, since the oscillator is stopped when shut
  assign rx_edge = rx_sync_r[1] != rx_sync_r[2];
  assign act_evt = act_sync_r[1] != act_sync_r[2];

  // latch the shutdown request bit of each configuration write
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      req_r <= 1'b0;
      wake_pend_r <= 1'b0;
    end else if (cfg_wr_in) begin
      req_r <= cfg_transceiver_power_down_pin_in;
      wake_pend_r <= !cfg_transceiver_power_down_pin_in;
    end else if (cs_rise) begin
      wake_pend_r <= 1'b0;
    end
  end

  // sequencer state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      USSC_RUN: begin
        if (req_r) begin
          state_nxt = USSC_DRAIN;
        end
      end
      USSC_DRAIN: begin
        if (!req_r) begin
          state_nxt = USSC_RUN;
        end else if (!tx_shift_busy_in && !tx_hold_full_in) begin
          state_nxt = USSC_SHUT;
        end
      end
      USSC_SHUT: begin
        if (!req_r && wake_pend_r && cs_rise) begin
          state_nxt = USSC_WAKE;
        end
      end
      USSC_WAKE: begin
        state_nxt = USSC_RUN;
      end
      default: begin
        state_nxt = USSC_RUN;
      end
    endcase
  end
  assign entering = (state_r == USSC_DRAIN) && (state_nxt == USSC_SHUT);
  assign leaving = (state_r == USSC_SHUT) && (state_nxt == USSC_WAKE);

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= USSC_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // oscillator enable; off only in the shut state, restarted on select rise
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      osc_run_r <= 1'b1;
    end else if (entering) begin
      osc_run_r <= 1'b0;
    end else if (leaving) begin
      osc_run_r <= 1'b1;
    end
  end

  // acknowledge flag
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else if (entering) begin
      ack_r <= 1'b1;
    end else if (leaving) begin
      ack_r <= 1'b0;
    end
  end

  // activity flag: cleared on entry and exit, set by any rx edge while shut;
  // an edge in the entry cycle itself still counts, so set beats clear
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      ra_r <= 1'b0;
    end else if (leaving) begin
      ra_r <= 1'b0;
    end else if (((state_r == USSC_SHUT) || entering) && (rx_edge || act_evt)) begin
      ra_r <= 1'b1;
    end else if (entering) begin
      ra_r <= 1'b0;
    end
  end

  // clear pulses on entry; the link is told by a toggle so its echo can be traced
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      flush_r <= 1'b0;
      clr_tgl_r <= 1'b0;
    end else begin
      flush_r <= entering;
      if (entering) begin
        clr_tgl_r <= ~clr_tgl_r;
      end
    end
  end

  // transmit empty is forced high for the whole shutdown
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      tx_force_r <= 1'b0;
    end else if (entering) begin
      tx_force_r <= 1'b1;
    end else if (leaving) begin
      tx_force_r <= 1'b0;
    end
  end

  // configuration fields; writable in every state, reinit leaves rts alone
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= USSC_CFG_RST;
    end else if (cfg_wr_in) begin
      cfg_r <= cfg_reinit_in ? USSC_CFG_RST : cfg_data_in;
    end
  end

  // rts is kept across reinitialization
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      rts_r <= 1'b0;
    end else if (rts_wr_in) begin
      rts_r <= rts_val_in;
    end
  end

  assign osc_if.osc_run = osc_run_r;
  assign osc_if.clr_tgl = clr_tgl_r;

  // the link state is kept on its own clock; it only runs when the oscillator does
  ussc_link u_link (
    .osc_clk_in(osc_clk_in),
    .osc_rst_b_in(rst_b),
    .rx_in(rx_in),
    .osc_if(osc_if)
  );

  // outputs
  assign osc_enable_out = osc_run_r;
  assign rx_fifo_flush_out = flush_r;
  assign shutdown_acknowledge_out = ack_r;
  assign activity_or_framing_flag_out = ra_r;
  assign tx_empty_force_out = tx_force_r;
  assign irq_b_out = !(ra_r && cfg_r[USSC_POS_RAM]);
  assign cts_out = cts_sync_r[2];
  assign rts_out = rts_r;
  assign cfg_out = cfg_r;

  // transceiver path: only the power-down pin matters here, never the uart state
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      drv_oe_out[i] = transceiver_power_down_pin_in;
      drv_data_out[i] = drv_data_in[i];
    end
  end
  assign line_rx_out = line_rx_in;
endmodule

/* verification/ussc_top_assertions.sv */
// ussc_checker: port-level checks of the uart shutdown sequencer.
// assumes one system clock domain; bound into every ussc_top.
module ussc_checker
  import ussc_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // inputs seen
  input wire logic cfg_wr_in,
  input wire logic cfg_reinit_in,
  input wire logic [ussc_pkg::USSC_CFG_W-1:0] cfg_data_in,
  input wire logic tx_shift_busy_in,
  input wire logic tx_hold_full_in,
  input wire logic rx_in,
  input wire logic transceiver_power_down_pin_in,
  input wire logic [1:0] line_rx_in,
  // outputs watched
  input wire logic osc_enable_out,
  input wire logic rx_fifo_flush_out,
  input wire logic shutdown_acknowledge_out,
  input wire logic activity_or_framing_flag_out,
  input wire logic tx_empty_force_out,
  input wire logic irq_b_out,
  input wire logic [ussc_pkg::USSC_CFG_W-1:0] cfg_out,
  input wire logic [1:0] drv_oe_out,
  input wire logic [1:0] line_rx_out
);
  import ussc_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_osc_held_off: assert property (shutdown_acknowledge_out |-> !osc_enable_out && tx_empty_force_out)
    else $error("oscillator or empty flag wrong while shut");
  a_drain_before_ack: assert property ($rose(shutdown_acknowledge_out) |-> $past(!tx_shift_busy_in && !tx_hold_full_in))
    else $error("shutdown entered with transmit busy");
  a_entry_flush: assert property ($rose(shutdown_acknowledge_out) |-> rx_fifo_flush_out ##1 !rx_fifo_flush_out)
    else $error("flush pulse wrong at entry");
  a_rx_edge_flag: assert property (shutdown_acknowledge_out && $changed(rx_in)
    |-> ##[1:6] (activity_or_framing_flag_out || !shutdown_acknowledge_out))
    else $error("activity flag not set by rx edge");
  a_irq_follows: assert property (irq_b_out == !(activity_or_framing_flag_out && cfg_out[USSC_POS_RAM]))
    else $error("interrupt does not follow flag and mask");
  a_exit_clean: assert property ($fell(shutdown_acknowledge_out) |-> osc_enable_out && !activity_or_framing_flag_out)
    else $error("exit did not restart oscillator or clear flag");
  a_cfg_taken: assert property (cfg_wr_in && !cfg_reinit_in ##1 $stable(cfg_data_in) |-> ##[0:1] cfg_out == cfg_data_in)
    else $error("configuration write not taken");
  a_reinit_zero: assert property (cfg_wr_in && cfg_reinit_in |-> ##[1:2] cfg_out == USSC_CFG_RST)
    else $error("restart write did not clear configuration");
  a_drv_enable: assert property (drv_oe_out == {2{transceiver_power_down_pin_in}})
    else $error("driver enable does not follow pin");
  a_rx_pass: assert property (line_rx_out == line_rx_in)
    else $error("receiver path blocked");
endmodule

bind ussc_top ussc_checker i_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_wr_in(cfg_wr_in), .cfg_reinit_in(cfg_reinit_in),
  .cfg_data_in(cfg_data_in), .tx_shift_busy_in(tx_shift_busy_in), .tx_hold_full_in(tx_hold_full_in),
  .rx_in(rx_in), .transceiver_power_down_pin_in(transceiver_power_down_pin_in), .line_rx_in(line_rx_in),
  .osc_enable_out(osc_enable_out), .rx_fifo_flush_out(rx_fifo_flush_out),
  .shutdown_acknowledge_out(shutdown_acknowledge_out), .activity_or_framing_flag_out(activity_or_framing_flag_out),
  .tx_empty_force_out(tx_empty_force_out), .irq_b_out(irq_b_out), .cfg_out(cfg_out),
  .drv_oe_out(drv_oe_out), .line_rx_out(line_rx_out)
);

/* verification/ussc_host_model.sv */
// ussc_host_model: host that frames configuration writes with chip select.
// assumes callers use its task; signals move 1 ns after a rising edge.
module ussc_host_model
  import ussc_pkg::*;
(
  // system clock
  input wire logic clk_in,
  // configuration write
  output logic cfg_wr_out,
  output logic cfg_transceiver_power_down_pin_out,
  output logic cfg_reinit_out,
  output logic [ussc_pkg::USSC_CFG_W-1:0] cfg_data_out,
  output logic cs_b_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import ussc_pkg::*;
  initial begin
    cfg_wr_out = 1'h0;
    cfg_transceiver_power_down_pin_out = 1'h0;
    cfg_reinit_out = 1'h0;
    cfg_data_out = 12'h000;
    cs_b_out = 1'h1;
  end
  // one framed transfer; released fields are inverted so stale values never look valid
  task automatic frame(input logic wr, input logic transceiver_power_down_pin, input logic reinit, input logic [USSC_CFG_W-1:0] d);
    @(posedge clk_in) #1;
    cs_b_out = 1'h0;
    cfg_transceiver_power_down_pin_out = transceiver_power_down_pin;
    cfg_reinit_out = reinit;
    cfg_data_out = d;
    repeat (2) @(posedge clk_in);
    #1 cfg_wr_out = wr;
    @(posedge clk_in) #1;
    cfg_wr_out = 1'h0;
    repeat (2) @(posedge clk_in);
    #1 cs_b_out = 1'h1;
    cfg_data_out = ~d;
    cfg_transceiver_power_down_pin_out = ~transceiver_power_down_pin;
    cfg_reinit_out = ~reinit;
    repeat (8) @(posedge clk_in);
    #1;
  endtask
endmodule

/* verification/test_uart_software_shutdown_control.sv */
// test_uart_software_shutdown_control: directed shutdown and wake tests.
// assumes design, host model and checker are compiled first.
module test_uart_software_shutdown_control;
  timeunit 1ns;
  timeprecision 100ps;
  import ussc_pkg::*;
  logic clk_in = 1'h0, rst_b_in = 1'h0, osc_clk = 1'h0;
  logic cfg_wr, cfg_transceiver_power_down_pin, cfg_reinit, cs_b, osc_en, flush, ack, flag, force_t, irq_b, cts_q, rts_q;
  logic rts_wr = 1'h0, rts_val = 1'h0, busy = 1'h0, hold = 1'h0, rx = 1'h1, cts = 1'h0, pin = 1'h1;
  logic [USSC_CFG_W-1:0] cfg_data, cfg_q;
  logic [1:0] drv_d = 2'h2, lrx = 2'h1, drv_q, oe, lrx_q;
  int mismatches = 0;
  int n_checks = 0;
  always #2 clk_in = ~clk_in;
  // oscillator stands still while the block has it off
  initial begin
    #7;
    forever #40 if (osc_en === 1'h1) osc_clk = ~osc_clk;
  end
  ussc_top i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .osc_clk_in(osc_clk), .cfg_wr_in(cfg_wr),
    .cfg_transceiver_power_down_pin_in(cfg_transceiver_power_down_pin), .cfg_reinit_in(cfg_reinit), .cfg_data_in(cfg_data), .rts_wr_in(rts_wr),
    .rts_val_in(rts_val), .cs_b_in(cs_b), .tx_shift_busy_in(busy), .tx_hold_full_in(hold), .rx_in(rx),
    .cts_in(cts), .transceiver_power_down_pin_in(pin), .drv_data_in(drv_d), .line_rx_in(lrx),
    .osc_enable_out(osc_en), .rx_fifo_flush_out(flush), .shutdown_acknowledge_out(ack),
    .activity_or_framing_flag_out(flag), .tx_empty_force_out(force_t), .irq_b_out(irq_b), .cts_out(cts_q),
    .rts_out(rts_q), .cfg_out(cfg_q), .drv_data_out(drv_q), .drv_oe_out(oe), .line_rx_out(lrx_q));
  ussc_host_model i_host (.clk_in(clk_in), .cfg_wr_out(cfg_wr), .cfg_transceiver_power_down_pin_out(cfg_transceiver_power_down_pin),
    .cfg_reinit_out(cfg_reinit), .cfg_data_out(cfg_data), .cs_b_out(cs_b));
  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // bounded wait; samples only after the edge's updates have landed
  task automatic wait_ack(input logic v);
    for (int i = 0; i < 60 && ack !== v; i++) tick(1);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // whole run is under 1000 cycles; ample margin
  initial begin
    #80000;
    mismatches++;
    conclude();
  end
  initial begin
    tick(4);
    rst_b_in = 1'h1;
    tick(4);
    chk("osc", 1'h1, osc_en);
    chk("irq_b", 1'h1, irq_b);
    chk("cfg", 12'h000, cfg_q);
    i_host.frame(1'h1, 1'h0, 1'h0, 12'h9ab);
    chk("cfg", 12'h9ab, cfg_q);
    rts_wr = 1'h1;
    rts_val = 1'h1;
    cts = 1'h1;
    tick(1);
    rts_wr = 1'h0;
    // shutdown must wait for both transmit stages
    busy = 1'h1;
    hold = 1'h1;
    i_host.frame(1'h1, 1'h1, 1'h0, 12'h9ab);
    busy = 1'h0;
    tick(10);
    chk("ack", 1'h0, ack);
    hold = 1'h0;
    wait_ack(1'h1);
    chk("ack", 1'h1, ack);
    chk("flush", 1'h1, flush);
    chk("osc", 1'h0, osc_en);
    chk("tx_force", 1'h1, force_t);
    chk("flag", 1'h0, flag);
    i_host.frame(1'h1, 1'h1, 1'h0, 12'h5c3);
    chk("cfg", 12'h5c3, cfg_q);
    chk("cts", 1'h1, cts_q);
    rx = 1'h0;
    tick(8);
    chk("flag", 1'h1, flag);
    chk("irq_b", 1'h0, irq_b);
    pin = 1'h0;
    lrx = 2'h2;
    tick(1);
    chk("drv_oe", 2'h0, oe);
    chk("line_rx", 2'h2, lrx_q);
    chk("ack", 1'h1, ack);
    pin = 1'h1;
    tick(2);
    chk("drv_oe", 2'h3, oe);
    chk("drv_data", 2'h2, drv_q);
    i_host.frame(1'h0, 1'h0, 1'h0, 12'h5c3);
    chk("ack", 1'h1, ack);
    i_host.frame(1'h1, 1'h0, 1'h0, 12'h5c3);
    chk("ack", 1'h0, ack);
    chk("osc", 1'h1, osc_en);
    chk("flag", 1'h0, flag);
    chk("tx_force", 1'h0, force_t);
    tick(20);
    i_host.frame(1'h1, 1'h0, 1'h1, 12'h5c3);
    chk("cfg", 12'h000, cfg_q);
    chk("rts", 1'h1, rts_q);
    // request withdrawn while draining: no shutdown
    busy = 1'h1;
    i_host.frame(1'h1, 1'h1, 1'h0, 12'h000);
    i_host.frame(1'h1, 1'h0, 1'h0, 12'h000);
    busy = 1'h0;
    tick(10);
    chk("ack", 1'h0, ack);
    conclude();
  end
endmodule
